/* File: logic/ffp_pkg.sv */
package ffp_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [3:0] FFP_OFF_ERR_FLAGS = 4'h0;
   localparam logic [3:0] FFP_OFF_PROT      = 4'h4;
   localparam logic [3:0] FFP_OFF_CONFIG    = 4'h8;
   localparam logic [3:0] FFP_OFF_STATUS    = 4'hc;

   // error flag field positions
   localparam int FFP_SFD_BIT = 0;
   localparam int FFP_DFD_BIT = 1;

   // protection register field positions
   localparam int FFP_OPEN_BIT = 7;
   localparam int FFP_RNV_BIT  = 6;
   localparam int FFP_HDIS_BIT = 5;
   localparam int FFP_HS_LSB   = 3;
   localparam int FFP_LDIS_BIT = 2;
   localparam int FFP_LS_LSB   = 0;

   // config and status positions
   localparam int FFP_IGN_SF_BIT  = 0;
   localparam int FFP_PVIOL_BIT   = 0;

   // value forced after a double fault on the reset load
   localparam logic [7:0] FFP_PROT_FAULT_VAL = 8'h7f;
   localparam logic [7:0] FFP_PROT_RST       = 8'h7f;
   localparam logic [7:0] FFP_CFG_RST        = 8'h00;

   // program flash window (global byte addresses)
   localparam logic [17:0] FFP_PF_BASE   = 18'h38000;
   localparam logic [17:0] FFP_PF_TOP    = 18'h3ffff;
   localparam logic [17:0] FFP_PROT_ADDR = 18'h3ff0c;
   localparam logic [17:0] FFP_HIGH_MIN  = 18'h00800;
   localparam logic [17:0] FFP_LOW_MIN   = 18'h00400;

   typedef struct packed {
      logic        valid;
      logic        erase;
      logic        block;
      logic [17:0] addr;
   } ffp_cmd_t;

   typedef struct packed {
      logic single_fault;
      logic double_fault;
      logic collision;
   } ffp_read_evt_t;
endpackage

/* File: logic/ffp_range_chk.sv */
`timescale 1ns/1ps
module ffp_range_chk
   import ffp_pkg::*;
(
   input  wire logic [7:0]  i_prot,
   input  wire logic [17:0] i_addr,
   output logic             o_prot_hit,
   output logic             o_any_prot
);
   import ffp_pkg::*;

   logic        open_sel;
   logic        in_high;
   logic        in_low;
   logic        high_on;
   logic        low_on;
   logic [17:0] high_size;
   logic [17:0] low_size;
   logic [17:0] high_start;
   logic [17:0] low_end;
   logic        in_pf;

   assign open_sel   = i_prot[FFP_OPEN_BIT];
   assign high_on    = ~i_prot[FFP_HDIS_BIT];
   assign low_on     = ~i_prot[FFP_LDIS_BIT];
   // high and low size doubling
   // 2k..16k and 1k..8k by doubling
   assign high_size  = FFP_HIGH_MIN << i_prot[FFP_HS_LSB +: 2];
   assign low_size   = FFP_LOW_MIN << i_prot[FFP_LS_LSB +: 2];
   assign high_start = 18'(FFP_PF_TOP - high_size + 18'h00001);
   assign low_end    = 18'(FFP_PF_BASE + low_size);
   assign in_pf      = i_addr >= FFP_PF_BASE;
   assign in_high    = high_on && i_addr >= high_start;
   assign in_low     = low_on && in_pf && i_addr < low_end;
   // select set protects
   // ranges protect when select set, stay open when clear
   assign o_prot_hit = in_pf &&
                       (open_sel ? (in_high || in_low) : !(in_high || in_low));
   assign o_any_prot = open_sel ? (high_on || low_on) : 1'b1;
endmodule // ffp_range_chk

/* File: logic/ffp_flash_guard.sv */
`timescale 1ns/1ps
// How it works
// - set double flag on 2-bit error/collision
// - double flag clears only on written one
// - single flag set on 1-bit error unless ignore-single set
// - single flag clears only on written one
// - ecc error sets only one flag
// - collision sets both flags together
// - flags readable, writes only clear
// - protection writes may only grow region
// - load protection byte during reset sequence
// - double fault on load protects everything
// - protected program/erase refused, violation flagged
// - block erase refused if any protected
// - select clear: ranges stay unprotected
// - select set: ranges become protected
// - high size 2/4/8/16k at top
// - low size 1/2/4/8k at base
// - size writable only while disable set
// - disallowed scenario transition ignored wholly
module ffp_flash_guard
   import ffp_pkg::*;
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_b,
   input  wire logic          i_wb_cyc,
   input  wire logic          i_wb_stb,
   input  wire logic          i_wb_we,
   input  wire logic [3:0]    i_wb_adr,
   input  wire logic [3:0]    i_wb_sel,
   input  wire logic [31:0]   i_wb_dat,
   output logic [31:0]        o_wb_dat,
   output logic               o_wb_ack,
   input  wire ffp_pkg::ffp_read_evt_t i_rd_evt,
   input  wire logic          i_load_vld,
   input  wire logic [7:0]    i_load_byte,
   input  wire logic          i_load_dfault,
   input  wire ffp_pkg::ffp_cmd_t i_cmd,
   output logic               o_cmd_ok,
   output logic               o_cmd_refused,
   output logic               o_ignore_single_fault
);
   import ffp_pkg::*;

   logic [1:0] err_reg;
   logic [1:0] err_next;
   logic [7:0] prot_reg;
   logic [7:0] prot_next;
   logic       cfg_ign_reg;
   logic       cfg_ign_next;
   logic       viol_reg;
   logic       viol_next;
   logic       ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;

   logic       req;
   logic       wr;
   logic       wr_b0;
   logic       wr_err;
   logic       wr_prot;
   logic       wr_cfg;
   logic       wr_stat;
   logic [1:0] clr_err;
   logic [1:0] set_err;
   logic       ecc_single;
   logic       ecc_double;
   logic       coll;
   logic [7:0] wdat;
   logic [7:0] prot_cand;
   logic [2:0] scen_cur;
   logic [2:0] scen_new;
   logic       trans_ok;
   logic       size_ok;
   logic       grow_ok;
   logic       hit;
   logic       any_prot;
   logic       refuse;
   logic [7:0] allow_row;

   assign req   = i_wb_cyc && i_wb_stb && !ack_reg;
   assign wr    = req && i_wb_we;
   assign wr_b0 = wr && i_wb_sel[0];
   assign wdat  = i_wb_dat[7:0];
   assign wr_err  = wr_b0 && i_wb_adr == FFP_OFF_ERR_FLAGS;
   assign wr_prot = wr_b0 && i_wb_adr == FFP_OFF_PROT;
   assign wr_cfg  = wr_b0 && i_wb_adr == FFP_OFF_CONFIG;
   assign wr_stat = wr_b0 && i_wb_adr == FFP_OFF_STATUS;

   // fault event decode
   assign coll       = i_rd_evt.collision;
   assign ecc_double = i_rd_evt.double_fault && !coll;
   assign ecc_single = i_rd_evt.single_fault && !i_rd_evt.double_fault
                       && !coll && !cfg_ign_reg;
   assign set_err[FFP_DFD_BIT] = ecc_double || coll;
   assign set_err[FFP_SFD_BIT] = ecc_single || coll;
   assign clr_err = wr_err ? wdat[1:0] : 2'b00;
   // set beats clear, writes never set
   assign err_next = set_err | (err_reg & ~clr_err);

   // scenario number: select, high disable, low disable
   assign scen_cur = {prot_reg[FFP_OPEN_BIT], prot_reg[FFP_HDIS_BIT],
                      prot_reg[FFP_LDIS_BIT]};
   // sizes only follow write while disable set
   assign prot_cand = {wdat[FFP_OPEN_BIT], prot_reg[FFP_RNV_BIT],
                       wdat[FFP_HDIS_BIT],
                       prot_reg[FFP_HDIS_BIT] ? wdat[FFP_HS_LSB +: 2]
                                              : prot_reg[FFP_HS_LSB +: 2],
                       wdat[FFP_LDIS_BIT],
                       prot_reg[FFP_LDIS_BIT] ? wdat[FFP_LS_LSB +: 2]
                                              : prot_reg[FFP_LS_LSB +: 2]};
   assign scen_new = {prot_cand[FFP_OPEN_BIT], prot_cand[FFP_HDIS_BIT],
                      prot_cand[FFP_LDIS_BIT]};
   always_comb begin
      unique case (scen_cur)
         3'd0: allow_row = 8'h0f;
         3'd1: allow_row = 8'h0a;
         3'd2: allow_row = 8'h0c;
         3'd3: allow_row = 8'h08;
         3'd4: allow_row = 8'h18;
         3'd5: allow_row = 8'h3c;
         3'd6: allow_row = 8'h5a;
         3'd7: allow_row = 8'hff;
      endcase
   end
   assign trans_ok = allow_row[scen_new];
   // ranges may only grow (open ones shrink)
   assign size_ok =
      (prot_cand[FFP_HDIS_BIT] ||
       (prot_cand[FFP_OPEN_BIT]
          ? prot_cand[FFP_HS_LSB +: 2] >= prot_reg[FFP_HS_LSB +: 2]
            || prot_reg[FFP_HDIS_BIT]
          : prot_cand[FFP_HS_LSB +: 2] <= prot_reg[FFP_HS_LSB +: 2]
            || prot_reg[FFP_HDIS_BIT])) &&
      (prot_cand[FFP_LDIS_BIT] ||
       (prot_cand[FFP_OPEN_BIT]
          ? prot_cand[FFP_LS_LSB +: 2] >= prot_reg[FFP_LS_LSB +: 2]
            || prot_reg[FFP_LDIS_BIT]
          : prot_cand[FFP_LS_LSB +: 2] <= prot_reg[FFP_LS_LSB +: 2]
            || prot_reg[FFP_LDIS_BIT]));
   assign grow_ok = trans_ok && size_ok;

   always_comb begin
      prot_next = prot_reg;
      if (i_load_vld) begin
         prot_next = i_load_dfault ? FFP_PROT_FAULT_VAL : i_load_byte;
      end else if (wr_prot && grow_ok) begin
         prot_next = prot_cand;
      end
   end

   ffp_range_chk u_range (
      .i_prot     (prot_reg),
      .i_addr     (i_cmd.addr),
      .o_prot_hit (hit),
      .o_any_prot (any_prot)
   );

   assign refuse = i_cmd.valid &&
                   (i_cmd.block ? (i_cmd.erase && any_prot) : hit);
   assign o_cmd_refused = refuse;
   assign o_cmd_ok      = i_cmd.valid && !refuse;
   // violation sticky, set beats clear
   assign viol_next = refuse ||
                      (viol_reg && !(wr_stat && wdat[FFP_PVIOL_BIT]));
   assign cfg_ign_next = wr_cfg ? wdat[FFP_IGN_SF_BIT] : cfg_ign_reg;

   always_comb begin
      rdat_next = 32'h00000000;
      unique case (i_wb_adr)
         FFP_OFF_ERR_FLAGS: rdat_next[1:0] = err_reg;
         FFP_OFF_PROT:      rdat_next[7:0] = prot_reg;
         FFP_OFF_CONFIG:    rdat_next[FFP_IGN_SF_BIT] = cfg_ign_reg;
         FFP_OFF_STATUS:    rdat_next[FFP_PVIOL_BIT] = viol_reg;
         default:           rdat_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         err_reg     <= 2'b00;
         prot_reg    <= FFP_PROT_RST;
         cfg_ign_reg <= FFP_CFG_RST[FFP_IGN_SF_BIT];
         viol_reg    <= 1'b0;
         ack_reg     <= 1'b0;
         rdat_reg    <= 32'h00000000;
      end else begin
         err_reg  <= err_next;
         prot_reg <= prot_next;
         viol_reg <= viol_next;
         ack_reg  <= req;
         rdat_reg <= rdat_next;
         cfg_ign_reg <= cfg_ign_next;
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   assign o_ignore_single_fault = cfg_ign_reg;

   dfd_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_rd_evt.double_fault || coll) |=> err_reg[FFP_DFD_BIT])
      else $error("double flag not set");
   dfd_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (err_reg[FFP_DFD_BIT] && !(wr_err && wdat[1])) |=> err_reg[FFP_DFD_BIT])
      else $error("double flag lost");
   sfd_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (wr_err && wdat[0] && !set_err[0]) |=> !err_reg[FFP_SFD_BIT])
      else $error("single flag not cleared");
   sfd_ignore_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (cfg_ign_reg && !coll && !err_reg[0]) |=> !err_reg[FFP_SFD_BIT])
      else $error("single flag set while ignored");
   ecc_excl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_rd_evt.double_fault && !coll && !err_reg[0] && !wr_err)
         |=> !err_reg[FFP_SFD_BIT])
      else $error("both flags on ecc");
   coll_both_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      coll |=> err_reg == 2'b11)
      else $error("collision flags wrong");
   prot_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (wr_prot && !grow_ok && !i_load_vld) |=> $stable(prot_reg))
      else $error("illegal protection write taken");
   load_fault_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_load_vld && i_load_dfault) |=> prot_reg == FFP_PROT_FAULT_VAL)
      else $error("fault load wrong");
   viol_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_cmd.valid && hit && !i_cmd.block) |-> o_cmd_refused ##1 viol_reg)
      else $error("violation not flagged");
endmodule // ffp_flash_guard

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
   import ffp_pkg::*;
   typedef struct packed {
      logic [7:0]  prot;
      logic        erase;
      logic        block;
      logic [17:0] addr;
      logic        refused;
   } ffp_row_t;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          cyc = 1'b0;
   logic          stb = 1'b0;
   logic          we = 1'b0;
   logic [3:0]    adr = 4'h0;
   logic [3:0]    sel = 4'h0;
   logic [31:0]   wdat = 32'h0;
   logic [31:0]   rdat;
   logic          ack;
   ffp_read_evt_t evt = '0;
   logic          ld_vld = 1'b0;
   logic [7:0]    ld_byte = 8'h00;
   logic          ld_df = 1'b0;
   ffp_cmd_t      cmd = '0;
   logic          ok;
   logic          refused;
   logic          ign;
   int            fails = 0;
   int            n_checks = 0;
   // bit 6 kept erased (high) in every load, the 8'h5f rows included
   // low lane of each word only
   ffp_row_t rows [16] = '{
      '{8'hff, 1'b0, 1'b0, 18'h38000, 1'b0},
      '{8'hff, 1'b1, 1'b1, 18'h38000, 1'b0},
      '{8'hfb, 1'b0, 1'b0, 18'h39fff, 1'b1},
      '{8'hfb, 1'b0, 1'b0, 18'h3a000, 1'b0},
      '{8'hfb, 1'b1, 1'b1, 18'h3f000, 1'b1},
      '{8'hf8, 1'b0, 1'b0, 18'h383ff, 1'b1},
      '{8'hf8, 1'b1, 1'b0, 18'h38400, 1'b0},
      '{8'hf9, 1'b0, 1'b0, 18'h38800, 1'b0},
      '{8'hfa, 1'b0, 1'b0, 18'h38fff, 1'b1},
      '{8'hc7, 1'b0, 1'b0, 18'h3f800, 1'b1},
      '{8'hc7, 1'b0, 1'b0, 18'h3f7ff, 1'b0},
      '{8'hcf, 1'b1, 1'b0, 18'h3efff, 1'b0},
      '{8'hd7, 1'b0, 1'b0, 18'h3e000, 1'b1},
      '{8'h5f, 1'b0, 1'b0, 18'h3bfff, 1'b1},
      '{8'hff, 1'b0, 1'b0, 18'h3ff0c, 1'b0},
      '{8'h5f, 1'b1, 1'b1, 18'h3c000, 1'b1}};
   ffp_read_evt_t ev [3] = '{3'b100, 3'b010, 3'b001};

   ffp_flash_guard dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rd_evt(evt),
      .i_load_vld(ld_vld), .i_load_byte(ld_byte), .i_load_dfault(ld_df),
      .i_cmd(cmd), .o_cmd_ok(ok), .o_cmd_refused(refused),
      .o_ignore_single_fault(ign));

   always #25 clk = ~clk;

   task automatic final_report();
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // holds the request until ack is seen, releases at that edge
   // no local limit: only the watchdog ends a hung wait
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 24'h0, d};
      do @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rd(input string nm, input logic [3:0] a,
                     input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, 4'h1, q);
      `CHK(nm, {24'h0, e}, q)
   endtask

   task automatic do_reset(input logic ld, input logic [7:0] b,
                           input logic df);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      {ld_vld, ld_byte, ld_df} <= {ld, b, df};
      @(posedge clk);
      {ld_vld, ld_df} <= 2'b00;
   endtask

   task automatic pulse(input ffp_read_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask

   task automatic cmd_chk(input ffp_row_t r);
      @(posedge clk);
      cmd <= {1'b1, r.erase, r.block, r.addr};
      @(negedge clk);
      `CHK("refused", r.refused, refused)
      `CHK("ok", ~r.refused, ok)
      @(posedge clk);
      cmd <= '0;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      final_report();
   end

   initial begin
      logic [31:0] q;
      do_reset(1'b0, 8'h00, 1'b0);
      rd("prot", FFP_OFF_PROT, 8'h7f);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h00);
      for (int i = 0; i < 16; i++) begin
         do_reset(1'b1, rows[i].prot, 1'b0);
         cmd_chk(rows[i]);
      end
      do_reset(1'b1, 8'hfb, 1'b0);
      rd("prot", FFP_OFF_PROT, 8'hfb);
      cmd_chk('{8'hfb, 1'b0, 1'b0, 18'h38000, 1'b1});
      rd("viol", FFP_OFF_STATUS, 8'h01);
      wr(FFP_OFF_STATUS, 8'h01);
      rd("viol", FFP_OFF_STATUS, 8'h00);
      wr(FFP_OFF_PROT, 8'hff);
      rd("prot", FFP_OFF_PROT, 8'hfb);
      wr(FFP_OFF_PROT, 8'hf8);
      rd("prot", FFP_OFF_PROT, 8'hfb);
      wr(FFP_OFF_PROT, 8'hdb);
      rd("prot", FFP_OFF_PROT, 8'hdb);
      cmd_chk('{8'hdb, 1'b0, 1'b0, 18'h3c000, 1'b1});
      for (int i = 0; i < 3; i++) begin
         pulse(ev[i]);
         rd("flags", FFP_OFF_ERR_FLAGS, 8'(i + 1));
         wr(FFP_OFF_ERR_FLAGS, 8'h03);
         rd("flags", FFP_OFF_ERR_FLAGS, 8'h00);
      end
      pulse(3'b110);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h02);
      wr(FFP_OFF_ERR_FLAGS, 8'h03);
      wr(FFP_OFF_CONFIG, 8'h01);
      `CHK("ign", 1'b1, ign)
      pulse(ev[0]);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h00);
      pulse(ev[2]);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h03);
      wr(FFP_OFF_ERR_FLAGS, 8'h00);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h03);
      wr(FFP_OFF_ERR_FLAGS, 8'h01);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h02);
      wr(FFP_OFF_ERR_FLAGS, 8'hfc);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h02);
      wb(1'b1, FFP_OFF_ERR_FLAGS, 8'h02, 4'h0, q);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h02);
      wr(FFP_OFF_ERR_FLAGS, 8'h02);
      rd("flags", FFP_OFF_ERR_FLAGS, 8'h00);
      wr(4'h2, 8'hff);
      rd("unmapped", 4'h2, 8'h00);
      do_reset(1'b1, 8'hff, 1'b1);
      rd("prot", FFP_OFF_PROT, 8'h7f);
      cmd_chk('{8'h7f, 1'b0, 1'b0, 18'h3c000, 1'b1});
      final_report();
   end
endmodule // tb
